// file: src/tpc_regs.vh
`ifndef TPC_REGS_VH
`define TPC_REGS_VH

// Command prefix bytes
`define TPC_ESC 8'h1B
`define TPC_FS 8'h1C
`define TPC_GS 8'h1D

// Second command bytes
`define TPC_CMD_SPEED 8'h73
`define TPC_CMD_PAPER 8'h63
`define TPC_PAPER_SUB 8'h31
`define TPC_CMD_IMAGE 8'h2A
`define TPC_CMD_INIT 8'h40
`define TPC_CMD_PULSE 8'h45
`define TPC_CMD_DETECT 8'h39
`define TPC_CMD_USER4 8'h72
`define TPC_CMD_DARK 8'h45
`define TPC_CMD_STATUS 8'h61

// Print speed arguments and codes
`define TPC_SPD_ARG_HIGH 8'h60
`define TPC_SPD_ARG_MED1 8'h61
`define TPC_SPD_ARG_MED2 8'h62
`define TPC_SPD_ARG_LOW 8'h63
`define TPC_SPD_HIGH 2'h0
`define TPC_SPD_MED 2'h1
`define TPC_SPD_LOW 2'h2

// Raster modes
`define TPC_IMG_DOUBLE 8'h61
`define TPC_IMG_SINGLE 8'h62

// Bytes per dot line for the three head widths
`define TPC_BPL_448_DW 7'h1C
`define TPC_BPL_448_SG 7'h38
`define TPC_BPL_576_DW 7'h24
`define TPC_BPL_576_SG 7'h48
`define TPC_BPL_832_DW 7'h34
`define TPC_BPL_832_SG 7'h68

// Paper type field
`define TPC_PAPER_DIR_BIT 5
`define TPC_PAPER_CUT 2'h1

// Detection enable bits
`define TPC_DET_FEED 0
`define TPC_DET_THERM 1
`define TPC_DET_VOLT 2
`define TPC_DET_HEADUP 3
`define TPC_DET_PLOW 5
`define TPC_DET_POUT 6

// Auto status enable bits
`define TPC_AS_OFFLINE 1
`define TPC_AS_ERROR 2
`define TPC_AS_LOAD 4

// Reset and initialise values
`define TPC_RST_PULSE 8'h39
`define TPC_RST_DARK 4'h3
`define TPC_RST_PAPER 2'h0
`define TPC_RST_DETECT 8'h4F
`define TPC_RST_AUTOST 8'h00
`define TPC_RST_USER4 8'h00
`define TPC_RST_FACE 8'h01
`define TPC_RST_PITCH 8'h1A
`define TPC_RST_TAB 8'h08
`define TPC_RST_PAGE 8'h2C
`define TPC_RST_MARK_MM 8'h02
`define TPC_DOTS_PER_MM 8'h08

`endif

// file: src/tpc_sync.v
`timescale 1ns/1ps
// Three-stage input synchroniser; output moves once stages two and three agree
module tpc_sync #(
   parameter WIDTH = 1
) (
   // Clock and reset
   input wire clk_sys,
   input wire reset_n,
   // Pins in, clean levels out
   input wire [WIDTH-1:0] pin_in,
   output reg [WIDTH-1:0] level_out
);
   reg [WIDTH-1:0] s1_r;
   reg [WIDTH-1:0] s2_r;
   reg [WIDTH-1:0] s3_r;
   integer i;

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         s1_r <= {WIDTH{1'b0}};
         s2_r <= {WIDTH{1'b0}};
         s3_r <= {WIDTH{1'b0}};
         level_out <= {WIDTH{1'b0}};
      end else begin
         s1_r <= pin_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         for (i = 0; i < WIDTH; i = i + 1) begin
            if (s2_r[i] == s3_r[i]) begin
               level_out[i] <= s3_r[i];
            end
         end
      end
   end
endmodule

// file: src/tpc_status_tx.v
`timescale 1ns/1ps
// Sends a latched four-byte status sequence to the serial transmitter
module tpc_status_tx (
   // Clock and reset
   input wire clk_sys,
   input wire reset_n,
   // Request and the bytes to send
   input wire send_req,
   input wire [7:0] byte1,
   input wire [7:0] byte2,
   input wire [7:0] byte3,
   input wire [7:0] byte4,
   output wire busy,
   // Byte handshake toward the serial transmitter
   output reg tx_valid,
   output reg [7:0] tx_data,
   input wire tx_ready
);
   reg [31:0] sh_r;
   reg [1:0] left_r;
   reg pend_r;

   assign busy = tx_valid | pend_r;

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         sh_r <= 32'h0000_0000;
         left_r <= 2'h0;
         pend_r <= 1'b0;
         tx_valid <= 1'b0;
         tx_data <= 8'h00;
      end else begin
         // A request during a sequence is held, not dropped
         if (send_req && tx_valid) begin
            pend_r <= 1'b1;
         end
         if (!tx_valid && (send_req || pend_r)) begin
            tx_valid <= 1'b1;
            tx_data <= byte1;
            sh_r <= {byte2, byte3, byte4, 8'h00};
            left_r <= 2'h3;
            pend_r <= 1'b0;
         end else if (tx_valid && tx_ready) begin
            if (left_r == 2'h0) begin
               tx_valid <= 1'b0;
            end else begin
               tx_data <= sh_r[31:24];
               sh_r <= {sh_r[23:0], 8'h00};
               left_r <= left_r - 2'h1;
            end
         end
      end
   end
endmodule

// file: src/tpc_parser.v
`timescale 1ns/1ps
`include "tpc_regs.vh"
// Operation
// - Speed command flushes buffer, then sets speed
// - Pulse width command loads eight-bit time
// - Darkness takes low four bits, default three
// - Paper bit five picks mark direction
// - Paper bits one-zero pick paper kind
// - Paper change waits for buffered data print
// - Cut sheets auto feed; leaving ejects form
// - Raster mode 61h double wide, 62h single
// - Dot lines are n1 plus 256 n2, with only n2 bits one-zero used
// - Raster consumes lines times bytes per line
// - Raster bytes left to right, bit7 first
// - Initialise clears print buffer, keeps receive buffer
// - Initialise restores typeface, pitch, tabs, page
// - Initialise enables detections except paper low
// - Initialise restores quality, speed, paper, mark distance
// - Bottom alignment, doubles any face, face 01h
// - Status goes out only on serial link
// - Status command stores mask, sends four bytes if mask nonzero
// - Auto status mask resets to zero
// - Mask bits four, two, one pick events
// - Status bytes carry the listed flag bits
// - Disabled detections read as OK
// - Fourth byte is last user status value
module tpc_parser (
   // Clock and reset
   input wire clk_sys,
   input wire reset_n,
   // Command byte stream from the receive buffer
   input wire rx_valid,
   input wire [7:0] rx_data,
   output wire rx_ready,
   // Print buffer handshake
   input wire buf_has_data,
   input wire flush_done,
   output reg print_flush,
   output reg clear_print_buf,
   output reg eject_form,
   // Configuration pins
   input wire [1:0] mech_sel,
   input wire par_mode_pin,
   // Sensor pins
   input wire feed_btn_pin,
   input wire offline_pin,
   input wire volt_err_pin,
   input wire head_temp_pin,
   input wire hw_err_pin,
   input wire mark_err_pin,
   input wire cutter_err_pin,
   input wire head_up_pin,
   input wire paper_out_pin,
   input wire paper_low_pin,
   input wire auto_load_evt,
   // Settings
   output reg [1:0] print_speed,
   output reg [7:0] pulse_width,
   output reg [3:0] darkness,
   output reg [1:0] paper_kind,
   output reg mark_reverse,
   output wire auto_load_en,
   output reg [7:0] detect_en,
   output reg [7:0] auto_status_en,
   output reg [7:0] type_face,
   output reg [7:0] line_pitch,
   output reg [7:0] tab_step,
   output reg [7:0] page_lines,
   output reg dbl_wide,
   output reg dbl_high,
   output reg reverse_video,
   output reg inverted,
   output reg label_mark_det,
   output reg [7:0] mark_dist_dots,
   output reg bottom_align,
   // Raster output to the print engine
   output reg dot_valid,
   output reg [7:0] dot_data,
   output reg dot_double,
   output reg dot_line_start,
   output reg dot_line_end,
   input wire dot_ready,
   // Serial status transmitter
   output wire tx_valid,
   output wire [7:0] tx_data,
   input wire tx_ready
);
   localparam S_IDLE = 11'h001;
   localparam S_ESC = 11'h002;
   localparam S_FS = 11'h004;
   localparam S_GS = 11'h008;
   localparam S_ARG = 11'h010;
   localparam S_PSUB = 11'h020;
   localparam S_IMG_M = 11'h040;
   localparam S_IMG_N1 = 11'h080;
   localparam S_IMG_N2 = 11'h100;
   localparam S_IMG_DATA = 11'h200;
   localparam S_FLUSH = 11'h400;

   localparam A_SPEED = 3'h0;
   localparam A_PAPER = 3'h1;
   localparam A_PULSE = 3'h2;
   localparam A_DETECT = 3'h3;
   localparam A_USER4 = 3'h4;
   localparam A_DARK = 3'h5;
   localparam A_STATUS = 3'h6;

   reg [10:0] st_r;
   reg [2:0] arg_r;
   reg [7:0] hold_r;
   reg [7:0] n1_r;
   reg [9:0] lines_r;
   reg [6:0] col_r;
   reg [6:0] bpl_r;
   reg [7:0] user4_r;
   reg status_cmd_r;
   reg [9:0] prev_r;
   reg [6:0] bpl_nxt;

   wire [10:0] sens;
   wire par_mode;
   wire [9:0] err_vec;
   wire [7:0] sb1;
   wire [7:0] sb2;
   wire [7:0] sb3;
   wire evt;
   wire take;
   wire apply;
   wire [7:0] arg_byte;
   wire out_free;

   tpc_sync #(
      .WIDTH(11)
   ) u_sync (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .pin_in({par_mode_pin, feed_btn_pin, offline_pin, volt_err_pin, head_temp_pin,
               hw_err_pin, mark_err_pin, cutter_err_pin, head_up_pin, paper_out_pin,
               paper_low_pin}),
      .level_out(sens)
   );

   assign par_mode = sens[10];
   // Masked flags; a disabled detection reads as OK
   assign err_vec[9] = sens[9] & detect_en[`TPC_DET_FEED];
   assign err_vec[8] = sens[8];
   assign err_vec[7] = sens[7] & detect_en[`TPC_DET_VOLT];
   assign err_vec[6] = sens[6] & detect_en[`TPC_DET_THERM];
   assign err_vec[5] = sens[5];
   assign err_vec[4] = sens[4];
   assign err_vec[3] = sens[3];
   assign err_vec[2] = sens[2] & detect_en[`TPC_DET_HEADUP];
   assign err_vec[1] = sens[1] & detect_en[`TPC_DET_POUT];
   assign err_vec[0] = sens[0] & detect_en[`TPC_DET_PLOW];

   assign sb1 = {1'b0, err_vec[9], 1'b0, auto_load_evt, err_vec[8], 3'h0};
   assign sb2 = {err_vec[7:2], 2'h0};
   assign sb3 = {5'h00, err_vec[1], 1'b0, err_vec[0]};

   // Auto status events: going off line, a new enabled error, an auto load
   assign evt = (auto_status_en[`TPC_AS_OFFLINE] & err_vec[8] & ~prev_r[8])
      | (auto_status_en[`TPC_AS_ERROR]
         & (|({err_vec[7:6], err_vec[2:0]} & ~{prev_r[7:6], prev_r[2:0]})))
      | (auto_status_en[`TPC_AS_LOAD] & auto_load_evt);

   tpc_status_tx u_tx (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .send_req((status_cmd_r | evt) & ~par_mode),
      .byte1(sb1),
      .byte2(sb2),
      .byte3(sb3),
      .byte4(user4_r),
      .busy(),
      .tx_valid(tx_valid),
      .tx_data(tx_data),
      .tx_ready(tx_ready)
   );

   assign auto_load_en = (paper_kind == `TPC_PAPER_CUT);
   assign out_free = ~dot_valid | dot_ready;
   // Raster bytes wait on the print engine; flushes stall the stream
   assign rx_ready = (st_r == S_FLUSH) ? 1'b0 : ((st_r == S_IMG_DATA) ? out_free : 1'b1);
   assign take = rx_valid & rx_ready;
   assign arg_byte = (st_r == S_FLUSH) ? hold_r : rx_data;
   assign apply = (st_r == S_FLUSH) ? flush_done : (st_r == S_ARG && take && !buf_has_data);

   always @* begin
      case (mech_sel)
         2'h0: bpl_nxt = (rx_data == `TPC_IMG_DOUBLE) ? `TPC_BPL_448_DW : `TPC_BPL_448_SG;
         2'h1: bpl_nxt = (rx_data == `TPC_IMG_DOUBLE) ? `TPC_BPL_576_DW : `TPC_BPL_576_SG;
         default: bpl_nxt = (rx_data == `TPC_IMG_DOUBLE) ? `TPC_BPL_832_DW : `TPC_BPL_832_SG;
      endcase
   end

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= S_IDLE;
         arg_r <= A_SPEED;
         hold_r <= 8'h00;
         n1_r <= 8'h00;
         lines_r <= 10'h000;
         col_r <= 7'h00;
         bpl_r <= 7'h00;
         user4_r <= `TPC_RST_USER4;
         status_cmd_r <= 1'b0;
         prev_r <= 10'h000;
         print_flush <= 1'b0;
         clear_print_buf <= 1'b0;
         eject_form <= 1'b0;
         print_speed <= `TPC_SPD_HIGH;
         pulse_width <= `TPC_RST_PULSE;
         darkness <= `TPC_RST_DARK;
         paper_kind <= `TPC_RST_PAPER;
         mark_reverse <= 1'b0;
         detect_en <= `TPC_RST_DETECT;
         auto_status_en <= `TPC_RST_AUTOST;
         type_face <= `TPC_RST_FACE;
         line_pitch <= `TPC_RST_PITCH;
         tab_step <= `TPC_RST_TAB;
         page_lines <= `TPC_RST_PAGE;
         dbl_wide <= 1'b0;
         dbl_high <= 1'b0;
         reverse_video <= 1'b0;
         inverted <= 1'b0;
         label_mark_det <= 1'b1;
         mark_dist_dots <= `TPC_RST_MARK_MM * `TPC_DOTS_PER_MM;
         bottom_align <= 1'b1;
         dot_valid <= 1'b0;
         dot_data <= 8'h00;
         dot_double <= 1'b0;
         dot_line_start <= 1'b0;
         dot_line_end <= 1'b0;
      end else begin
         status_cmd_r <= 1'b0;
         clear_print_buf <= 1'b0;
         eject_form <= 1'b0;
         prev_r <= err_vec;
         bottom_align <= 1'b1;
         if (dot_valid && dot_ready) begin
            dot_valid <= 1'b0;
         end
         case (st_r)
            S_IDLE: begin
               if (take) begin
                  if (rx_data == `TPC_ESC) begin
                     st_r <= S_ESC;
                  end else if (rx_data == `TPC_FS) begin
                     st_r <= S_FS;
                  end else if (rx_data == `TPC_GS) begin
                     st_r <= S_GS;
                  end
               end
            end
            S_ESC: begin
               if (take) begin
                  st_r <= S_IDLE;
                  if (rx_data == `TPC_CMD_SPEED) begin
                     arg_r <= A_SPEED;
                     st_r <= S_ARG;
                  end else if (rx_data == `TPC_CMD_PAPER) begin
                     st_r <= S_PSUB;
                  end else if (rx_data == `TPC_CMD_IMAGE) begin
                     st_r <= S_IMG_M;
                  end else if (rx_data == `TPC_CMD_INIT) begin
                     // Only the print side is cleared; queued input stays
                     clear_print_buf <= 1'b1;
                     type_face <= `TPC_RST_FACE;
                     line_pitch <= `TPC_RST_PITCH;
                     tab_step <= `TPC_RST_TAB;
                     page_lines <= `TPC_RST_PAGE;
                     dbl_wide <= 1'b0;
                     dbl_high <= 1'b0;
                     reverse_video <= 1'b0;
                     inverted <= 1'b0;
                     detect_en <= `TPC_RST_DETECT;
                     darkness <= `TPC_RST_DARK;
                     print_speed <= `TPC_SPD_HIGH;
                     paper_kind <= `TPC_RST_PAPER;
                     mark_reverse <= 1'b0;
                     label_mark_det <= 1'b1;
                     mark_dist_dots <= `TPC_RST_MARK_MM * `TPC_DOTS_PER_MM;
                     if (paper_kind == `TPC_PAPER_CUT) begin
                        eject_form <= 1'b1;
                     end
                  end
               end
            end
            S_FS: begin
               if (take) begin
                  st_r <= S_ARG;
                  if (rx_data == `TPC_CMD_PULSE) begin
                     arg_r <= A_PULSE;
                  end else if (rx_data == `TPC_CMD_DETECT) begin
                     arg_r <= A_DETECT;
                  end else if (rx_data == `TPC_CMD_USER4) begin
                     arg_r <= A_USER4;
                  end else begin
                     st_r <= S_IDLE;
                  end
               end
            end
            S_GS: begin
               if (take) begin
                  st_r <= S_ARG;
                  if (rx_data == `TPC_CMD_DARK) begin
                     arg_r <= A_DARK;
                  end else if (rx_data == `TPC_CMD_STATUS) begin
                     arg_r <= A_STATUS;
                  end else begin
                     st_r <= S_IDLE;
                  end
               end
            end
            S_PSUB: begin
               if (take) begin
                  st_r <= (rx_data == `TPC_PAPER_SUB) ? S_ARG : S_IDLE;
                  arg_r <= A_PAPER;
               end
            end
            S_ARG: begin
               if (take) begin
                  st_r <= S_IDLE;
                  hold_r <= rx_data;
                  case (arg_r)
                     A_SPEED, A_PAPER: begin
                        // Settings that change the printed look wait for the buffer
                        if (buf_has_data) begin
                           print_flush <= 1'b1;
                           st_r <= S_FLUSH;
                        end
                     end
                     A_PULSE: pulse_width <= rx_data;
                     A_DETECT: detect_en <= rx_data;
                     A_USER4: user4_r <= rx_data;
                     A_DARK: darkness <= rx_data[3:0];
                     A_STATUS: begin
                        auto_status_en <= rx_data;
                        status_cmd_r <= (rx_data != 8'h00);
                     end
                     default: st_r <= S_IDLE;
                  endcase
               end
            end
            S_FLUSH: begin
               if (flush_done) begin
                  print_flush <= 1'b0;
                  st_r <= S_IDLE;
               end
            end
            S_IMG_M: begin
               if (take) begin
                  dot_double <= (rx_data == `TPC_IMG_DOUBLE);
                  bpl_r <= bpl_nxt;
                  st_r <= S_IMG_N1;
               end
            end
            S_IMG_N1: begin
               if (take) begin
                  n1_r <= rx_data;
                  st_r <= S_IMG_N2;
               end
            end
            S_IMG_N2: begin
               if (take) begin
                  lines_r <= {rx_data[1:0], n1_r};
                  col_r <= 7'h00;
                  // A zero count carries no data; decoding resumes at once
                  st_r <= ({rx_data[1:0], n1_r} == 10'h000) ? S_IDLE : S_IMG_DATA;
               end
            end
            S_IMG_DATA: begin
               if (take) begin
                  dot_valid <= 1'b1;
                  dot_data <= rx_data;
                  dot_line_start <= (col_r == 7'h00);
                  dot_line_end <= (col_r == bpl_r - 7'h01);
                  if (col_r == bpl_r - 7'h01) begin
                     col_r <= 7'h00;
                     lines_r <= lines_r - 10'h001;
                     if (lines_r == 10'h001) begin
                        st_r <= S_IDLE;
                     end
                  end else begin
                     col_r <= col_r + 7'h01;
                  end
               end
            end
            default: st_r <= S_IDLE;
         endcase
         if (apply && arg_r == A_SPEED) begin
            if (arg_byte == `TPC_SPD_ARG_HIGH) begin
               print_speed <= `TPC_SPD_HIGH;
            end else if (arg_byte == `TPC_SPD_ARG_MED1 || arg_byte == `TPC_SPD_ARG_MED2) begin
               print_speed <= `TPC_SPD_MED;
            end else if (arg_byte == `TPC_SPD_ARG_LOW) begin
               print_speed <= `TPC_SPD_LOW;
            end
         end else if (apply && arg_r == A_PAPER) begin
            paper_kind <= arg_byte[1:0];
            mark_reverse <= arg_byte[`TPC_PAPER_DIR_BIT];
            eject_form <= (paper_kind == `TPC_PAPER_CUT)
               && (arg_byte[1:0] != `TPC_PAPER_CUT);
         end
      end
   end
endmodule

// file: dv/tpc_parser_asserts.sv
`timescale 1ns/1ps
module tpc_parser_asserts (
   // Clock and reset
   input wire clk_sys,
   input wire reset_n,
   // Stream and flush
   input wire rx_ready,
   input wire flush_done,
   input wire print_flush,
   input wire clear_print_buf,
   input wire eject_form,
   // Settings
   input wire [1:0] print_speed,
   input wire [1:0] paper_kind,
   input wire auto_load_en,
   input wire [7:0] detect_en,
   input wire [7:0] line_pitch,
   input wire [7:0] page_lines,
   // Raster and status
   input wire dot_valid,
   input wire [7:0] dot_data,
   input wire dot_ready,
   input wire tx_valid,
   input wire [7:0] tx_data,
   input wire tx_ready
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   property p_flush_hold; print_flush |-> !rx_ready; endproperty
   a_flush_hold: assert property (p_flush_hold) else $error("rx_ready high in flush");
   property p_flush_end; print_flush && flush_done |=> !print_flush && rx_ready; endproperty
   a_flush_end: assert property (p_flush_end) else $error("flush not ended");
   property p_speed; print_speed != 2'h3; endproperty
   a_speed: assert property (p_speed) else $error("bad speed code");
   property p_init; clear_print_buf |-> detect_en == 8'h4F && line_pitch == 8'h1A
      && page_lines == 8'h2C && print_speed == 2'h0; endproperty
   a_init: assert property (p_init) else $error("init values wrong");
   property p_eject; eject_form |-> $past(paper_kind) == 2'h1 && paper_kind != 2'h1; endproperty
   a_eject: assert property (p_eject) else $error("eject without leaving cut");
   property p_autold; auto_load_en == (paper_kind == 2'h1); endproperty
   a_autold: assert property (p_autold) else $error("auto load mismatch");
   property p_tx_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("status byte dropped");
   property p_dot_hold; dot_valid && !dot_ready |=> dot_valid && $stable(dot_data); endproperty
   a_dot_hold: assert property (p_dot_hold) else $error("raster byte dropped");
endmodule

bind tpc_parser tpc_parser_asserts u_chk (.clk_sys(clk_sys), .reset_n(reset_n),
   .rx_ready(rx_ready), .flush_done(flush_done), .print_flush(print_flush),
   .clear_print_buf(clear_print_buf), .eject_form(eject_form), .print_speed(print_speed),
   .paper_kind(paper_kind), .auto_load_en(auto_load_en), .detect_en(detect_en),
   .line_pitch(line_pitch), .page_lines(page_lines), .dot_valid(dot_valid),
   .dot_data(dot_data), .dot_ready(dot_ready), .tx_valid(tx_valid), .tx_data(tx_data),
   .tx_ready(tx_ready));

// file: dv/tpc_host.sv
`timescale 1ns/1ps
module tpc_host (
   // Clock
   input wire clk_sys,
   // Command bytes out
   output logic rx_valid,
   output logic [7:0] rx_data,
   input wire rx_ready,
   // Serial status in
   input wire tx_valid,
   input wire [7:0] tx_data,
   output logic tx_ready
);
   logic [7:0] q[$];
   logic slow;
   initial begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
      tx_ready = 1'b1;
      slow = 1'b0;
   end
   // Slow mode stalls the status line every other cycle
   always @(negedge clk_sys) tx_ready <= slow ? ~tx_ready : 1'b1;
   always @(posedge clk_sys) if (tx_valid && tx_ready) q.push_back(tx_data);
   task send(input logic [7:0] b);
      @(negedge clk_sys);
      rx_valid = 1'b1;
      rx_data = b;
      @(posedge clk_sys);
      while (rx_ready !== 1'b1) @(posedge clk_sys);
   endtask
   // Released data shows the inverse so a stale byte is never mistaken for a new one
   task stop;
      @(negedge clk_sys);
      rx_valid = 1'b0;
      rx_data = ~rx_data;
   endtask
endmodule

// file: dv/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0, ld_evt = 1'b0;
   logic buf_has_data = 1'b0, flush_done = 1'b0, par_mode_pin = 1'b0, dot_ready = 1'b1;
   logic [1:0] mech_sel = 2'h1;
   logic [9:0] sens = 10'h000;
   wire rx_valid, rx_ready, print_flush, clear_print_buf, eject_form, mark_reverse;
   wire auto_load_en, label_mark_det, dbl_wide, dot_valid, dot_double, dot_line_end;
   wire tx_valid, tx_ready, dbl_high, bottom_align;
   wire [1:0] print_speed, paper_kind;
   wire [3:0] darkness;
   wire [7:0] rx_data, pulse_width, detect_en, auto_status_en, type_face, tab_step;
   wire [7:0] mark_dist_dots, tx_data, line_pitch, page_lines, dot_data;
   int err_count = 0, checked = 0, cyc = 0, ndot = 0, nend = 0, nej = 0, nclr = 0;
   logic [7:0] spd [4] = '{8'h00, 8'h01, 8'h01, 8'h02};
   logic [7:0] st [4] = '{8'h48, 8'hFC, 8'h04, 8'h5A};
   logic [7:0] im_m [2] = '{8'h61, 8'h62};
   int im_n [2] = '{36, 56};
   always #25 clk_sys = ~clk_sys;
   always @(negedge clk_sys) dot_ready <= ~dot_ready;
   tpc_host h (.clk_sys(clk_sys), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
      .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
   tpc_parser uut (.clk_sys(clk_sys), .reset_n(reset_n), .rx_valid(rx_valid),
      .rx_data(rx_data), .rx_ready(rx_ready), .buf_has_data(buf_has_data),
      .flush_done(flush_done), .print_flush(print_flush), .clear_print_buf(clear_print_buf),
      .eject_form(eject_form), .mech_sel(mech_sel), .par_mode_pin(par_mode_pin),
      .feed_btn_pin(sens[0]), .offline_pin(sens[1]), .volt_err_pin(sens[2]),
      .head_temp_pin(sens[3]), .hw_err_pin(sens[4]), .mark_err_pin(sens[5]),
      .cutter_err_pin(sens[6]), .head_up_pin(sens[7]), .paper_out_pin(sens[8]),
      .paper_low_pin(sens[9]), .auto_load_evt(ld_evt), .print_speed(print_speed),
      .pulse_width(pulse_width), .darkness(darkness), .paper_kind(paper_kind),
      .mark_reverse(mark_reverse), .auto_load_en(auto_load_en), .detect_en(detect_en),
      .auto_status_en(auto_status_en), .type_face(type_face), .line_pitch(line_pitch),
      .tab_step(tab_step), .page_lines(page_lines), .dbl_wide(dbl_wide), .dbl_high(dbl_high),
      .reverse_video(), .inverted(), .label_mark_det(label_mark_det),
      .mark_dist_dots(mark_dist_dots), .bottom_align(bottom_align), .dot_valid(dot_valid),
      .dot_data(dot_data), .dot_double(dot_double), .dot_line_start(), .dot_line_end(dot_line_end),
      .dot_ready(dot_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
   always @(posedge clk_sys) begin
      cyc++;
      if (dot_valid && dot_ready) ndot++;
      if (dot_valid && dot_ready && dot_line_end) nend++;
      if (eject_form) nej++;
      if (clear_print_buf) nclr++;
      if (cyc == 4000) begin
         err_count++;
         results;
      end
   end
   task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task tick(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task cmd(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
      h.send(a);
      h.send(b);
      h.send(c);
      h.stop;
   endtask
   task results;
      if (err_count == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      tick(16);
      reset_n = 1'b1;
      sens = 10'h3FF;
      tick(6);
      chk("pulse", pulse_width, 8'h39);
      chk("dark", darkness, 8'h03);
      chk("paper", paper_kind, 8'h00);
      chk("autost", auto_status_en, 8'h00);
      chk("face", type_face, 8'h01);
      chk("align", bottom_align, 8'h01);
      for (int i = 0; i < 4; i++) begin
         cmd(8'h1B, 8'h73, 8'h60 + i[7:0]);
         chk("speed", print_speed, spd[i]);
      end
      buf_has_data = 1'b1;
      cmd(8'h1B, 8'h73, 8'h60);
      tick(3);
      chk("flushing", print_flush, 8'h01);
      chk("speed_held", print_speed, 8'h02);
      flush_done = 1'b1;
      tick(1);
      flush_done = 1'b0;
      buf_has_data = 1'b0;
      tick(1);
      chk("speed_new", print_speed, 8'h00);
      h.send(8'h1B);
      cmd(8'h63, 8'h31, 8'h21);
      chk("kind", paper_kind, 8'h01);
      chk("rev", mark_reverse, 8'h01);
      chk("autold", auto_load_en, 8'h01);
      h.send(8'h1B);
      cmd(8'h63, 8'h31, 8'hDE);
      tick(1);
      chk("kind2", paper_kind, 8'h02);
      chk("rev2", mark_reverse, 8'h00);
      chk("eject", 8'(nej), 8'h01);
      cmd(8'h1C, 8'h45, 8'h80);
      cmd(8'h1D, 8'h45, 8'hA7);
      chk("pulse2", pulse_width, 8'h80);
      chk("dark2", darkness, 8'h07);
      for (int k = 0; k < 2; k++) begin
         mech_sel = 2'h1 - k[1:0];
         ndot = 0;
         nend = 0;
         h.send(8'h1B);
         h.send(8'h2A);
         h.send(im_m[k]);
         h.send(8'h01);
         h.send(8'h00);
         repeat (im_n[k]) h.send(8'h1B);
         cmd(8'h1C, 8'h45, 8'h22 + k[7:0]);
         tick(4);
         chk("ndot", 8'(ndot), 8'(im_n[k]));
         chk("nend", 8'(nend), 8'h01);
         chk("double", dot_double, 8'(1 - k));
         chk("after", pulse_width, 8'h22 + k[7:0]);
         chk("data", dot_data, 8'h1B);
      end
      h.slow = 1'b1;
      cmd(8'h1C, 8'h72, 8'h5A);
      cmd(8'h1D, 8'h61, 8'h7F);
      cmd(8'h1D, 8'h61, 8'h00);
      tick(30);
      chk("nbytes", 8'(h.q.size()), 8'h04);
      for (int i = 0; i < 4; i++) chk("status", h.q[i], st[i]);
      chk("autost_off", auto_status_en, 8'h00);
      cmd(8'h1D, 8'h61, 8'h10);
      tick(12);
      ld_evt = 1'b1;
      tick(1);
      ld_evt = 1'b0;
      tick(12);
      chk("load_status", h.q[8], 8'h58);
      par_mode_pin = 1'b1;
      tick(6);
      h.q.delete();
      cmd(8'h1D, 8'h61, 8'h7F);
      cmd(8'h1D, 8'h61, 8'h00);
      tick(20);
      chk("par_quiet", 8'(h.q.size()), 8'h00);
      cmd(8'h1B, 8'h73, 8'h63);
      h.send(8'h1B);
      h.send(8'h40);
      h.stop;
      tick(1);
      chk("init_clr", 8'(nclr), 8'h01);
      chk("init_spd", print_speed, 8'h00);
      chk("init_pap", paper_kind, 8'h00);
      chk("init_dark", darkness, 8'h03);
      chk("init_tab", tab_step, 8'h08);
      chk("init_dw", dbl_wide, 8'h00);
      chk("init_dh", dbl_high, 8'h00);
      chk("init_pitch", line_pitch, 8'h1A);
      chk("init_page", page_lines, 8'h2C);
      chk("init_det", detect_en, 8'h4F);
      chk("init_lbl", label_mark_det, 8'h01);
      chk("init_mk", mark_dist_dots, 8'h10);
      results;
   end
endmodule
